// *** rt_cfg2_defines.svh ***
`ifndef RT_CFG2_DEFINES_SVH
`define RT_CFG2_DEFINES_SVH

// register map
`define RT_CFG2_OFFSET       16'h0001
`define RT_CFG2_RESET        16'h0000
`define RT_CFG2_IMPL_MASK    16'hF000

// field positions
`define RT_TOSEL_HI          15
`define RT_TOSEL_LO          14
`define RT_TRXB_BIT          13
`define RT_TIME_TAG_LOAD_STROBE_BIT        12

// timing
`define RT_CLK_MHZ           20
`define RT_TIMEOUT_US_11     150
`define RT_TIMEOUT_US_10     125
`define RT_TIMEOUT_US_01     100
`define RT_TIMEOUT_US_00     57
`define RT_TIMEOUT_CYC_11    (`RT_TIMEOUT_US_11 * `RT_CLK_MHZ)
`define RT_TIMEOUT_CYC_10    (`RT_TIMEOUT_US_10 * `RT_CLK_MHZ)
`define RT_TIMEOUT_CYC_01    (`RT_TIMEOUT_US_01 * `RT_CLK_MHZ)
`define RT_TIMEOUT_CYC_00    (`RT_TIMEOUT_US_00 * `RT_CLK_MHZ)

// holding buffer
`define RT_HOLD_DEPTH        32

`endif

// *** rt_cfg2_pkg.sv ***
package rt_cfg2_pkg;
    typedef logic [15:0] word_t;
    typedef logic [4:0]  word_index_t;
    typedef logic [5:0]  word_count_t;
    typedef logic [11:0] timer_t;

    typedef enum logic {
        TO_IDLE = 1'b0,
        TO_WAIT = 1'b1
    } timeout_state_t;

    typedef enum logic {
        HB_COLLECT = 1'b0,
        HB_BURST   = 1'b1
    } hold_state_t;
endpackage

// *** hold_buffer_if.sv ***
`timescale 1ns/1ns
interface hold_buffer_if;
    import rt_cfg2_pkg::*;
    logic        wr_valid;
    word_index_t wr_index;
    word_t       wr_data;
    logic        commit;
    logic        discard;
    logic        busy;
    logic        mem_we;
    word_index_t mem_addr;
    word_t       mem_data;

    modport ctrl (output wr_valid, wr_index, wr_data, commit, discard,
                  input  busy, mem_we, mem_addr, mem_data);
    modport hold (input  wr_valid, wr_index, wr_data, commit, discard,
                  output busy, mem_we, mem_addr, mem_data);
endinterface

// *** hold_buffer.sv ***
`timescale 1ns/1ns
`include "rt_cfg2_defines.svh"
module hold_buffer
    import rt_cfg2_pkg::*;
(
    input  wire logic  sys_clk_in,
    input  wire logic  resetn_in,
    hold_buffer_if.hold hb
);
    word_t       store_reg [`RT_HOLD_DEPTH];
    word_t       store_next [`RT_HOLD_DEPTH];
    hold_state_t state_reg;
    hold_state_t state_next;
    word_count_t count_reg;
    word_count_t count_next;
    word_count_t ptr_reg;
    word_count_t ptr_next;
    logic        we_reg;
    logic        we_next;
    word_index_t addr_reg;
    word_index_t addr_next;
    word_t       data_reg;
    word_t       data_next;

    always_comb begin
        store_next = store_reg;
        state_next = state_reg;
        count_next = count_reg;
        ptr_next   = ptr_reg;
        we_next    = 1'b0;
        addr_next  = addr_reg;
        data_next  = data_reg;
        unique case (state_reg)
            HB_COLLECT: begin
                if (hb.wr_valid) begin
                    // words held aside, memory untouched
                    store_next[hb.wr_index] = hb.wr_data;
                    if ({1'b0, hb.wr_index} >= count_reg) begin
                        count_next = word_count_t'({1'b0, hb.wr_index} + 6'h01);
                    end
                end
                if (hb.discard) begin
                    count_next = 6'h00;
                end else if (hb.commit && count_next != 6'h00) begin
                    // error-free end starts the burst
                    state_next = HB_BURST;
                    ptr_next   = 6'h00;
                end
            end
            HB_BURST: begin
                // one held word per cycle to data memory
                we_next   = 1'b1;
                addr_next = ptr_reg[4:0];
                data_next = store_reg[ptr_reg[4:0]];
                ptr_next  = ptr_reg + 6'h01;
                if (ptr_next == count_reg) begin
                    state_next = HB_COLLECT;
                    count_next = 6'h00;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= HB_COLLECT;
            count_reg <= 6'h00;
            ptr_reg   <= 6'h00;
            we_reg    <= 1'b0;
            addr_reg  <= 5'h00;
            data_reg  <= 16'h0000;
            for (int i = 0; i < `RT_HOLD_DEPTH; i++) begin
                store_reg[i] <= 16'h0000;
            end
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            ptr_reg   <= ptr_next;
            we_reg    <= we_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            store_reg <= store_next;
        end
    end

    assign hb.busy     = (state_reg == HB_BURST);
    assign hb.mem_we   = we_reg;
    assign hb.mem_addr = addr_reg;
    assign hb.mem_data = data_reg;

    burst_on_commit_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (state_reg == HB_COLLECT) ##1 (state_reg == HB_BURST) |-> $past(hb.commit) && !$past(hb.discard))
        else $error("burst started without clean commit");
endmodule

// *** rt_config_two_controls.sv ***
`timescale 1ns/1ns
`include "rt_cfg2_defines.svh"
module rt_config_two_controls
    import rt_cfg2_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        soft_reset_in,
    input  wire logic [15:0] host_addr_in,
    input  wire logic        host_wr_in,
    input  wire logic        host_rd_in,
    input  wire logic [15:0] host_wdata_in,
    output logic      [15:0] host_rdata_out,
    input  wire logic        rtrt_wait_start_in,
    input  wire logic        rtrt_tx_begun_in,
    output logic             rtrt_timeout_error_out,
    input  wire logic        rx_word_valid_in,
    input  wire logic [4:0]  rx_word_index_in,
    input  wire logic [15:0] rx_word_in,
    input  wire logic        msg_done_in,
    input  wire logic        msg_error_in,
    output logic             mem_we_out,
    output logic      [4:0]  mem_addr_out,
    output logic      [15:0] mem_data_out,
    input  wire logic [15:0] time_tag_utility_in,
    output logic             time_tag_load_out,
    output logic      [15:0] time_tag_value_out,
    output logic             temp_receive_buffer_enable_out
);
    function automatic timer_t timeout_limit(input logic [1:0] sel);
        unique case (sel)
            2'b11:   timeout_limit = timer_t'(`RT_TIMEOUT_CYC_11);
            2'b10:   timeout_limit = timer_t'(`RT_TIMEOUT_CYC_10);
            2'b01:   timeout_limit = timer_t'(`RT_TIMEOUT_CYC_01);
            default: timeout_limit = timer_t'(`RT_TIMEOUT_CYC_00);
        endcase
    endfunction

    hold_buffer_if hb ();

    hold_buffer u_hold (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .hb         (hb)
    );

    word_t          cfg_reg;
    word_t          cfg_next;
    word_t          rdata_reg;
    word_t          rdata_next;
    logic           load_reg;
    logic           load_next;
    word_t          tt_value_reg;
    word_t          tt_value_next;
    timeout_state_t to_state_reg;
    timeout_state_t to_state_next;
    timer_t         timer_reg;
    timer_t         timer_next;
    logic           to_err_reg;
    logic           to_err_next;
    logic           mem_we_reg;
    logic           mem_we_next;
    word_index_t    mem_addr_reg;
    word_index_t    mem_addr_next;
    word_t          mem_data_reg;
    word_t          mem_data_next;
    logic           cfg_hit;
    logic           hold_en;
    timer_t         limit;

    assign cfg_hit = (host_addr_in == `RT_CFG2_OFFSET);
    assign hold_en = cfg_reg[`RT_TRXB_BIT];
    assign limit   = timeout_limit(cfg_reg[`RT_TOSEL_HI:`RT_TOSEL_LO]);

    // register, read port and time-tag load
    always_comb begin
        cfg_next      = cfg_reg;
        load_next     = 1'b0;
        tt_value_next = tt_value_reg;
        rdata_next    = rdata_reg;
        if (load_reg) begin
            cfg_next[`RT_TIME_TAG_LOAD_STROBE_BIT] = 1'b0;
        end
        if (host_wr_in && cfg_hit) begin
            // soft_reset_in deliberately not used here
            cfg_next = host_wdata_in & `RT_CFG2_IMPL_MASK;
            if (!cfg_reg[`RT_TIME_TAG_LOAD_STROBE_BIT] && host_wdata_in[`RT_TIME_TAG_LOAD_STROBE_BIT]) begin
                load_next     = 1'b1;
                tt_value_next = time_tag_utility_in;
            end
        end
        if (host_rd_in) begin
            rdata_next = cfg_hit ? cfg_reg : 16'h0000;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_reg      <= `RT_CFG2_RESET;
            load_reg     <= 1'b0;
            tt_value_reg <= 16'h0000;
            rdata_reg    <= 16'h0000;
        end else begin
            cfg_reg      <= cfg_next;
            load_reg     <= load_next;
            tt_value_reg <= tt_value_next;
            rdata_reg    <= rdata_next;
        end
    end

    // RT-RT no-response timer
    always_comb begin
        to_state_next = to_state_reg;
        timer_next    = timer_reg;
        to_err_next   = 1'b0;
        unique case (to_state_reg)
            TO_IDLE: begin
                if (rtrt_wait_start_in) begin
                    to_state_next = TO_WAIT;
                    timer_next    = 12'h001;
                end
            end
            TO_WAIT: begin
                if (rtrt_tx_begun_in) begin
                    to_state_next = TO_IDLE;
                end else if (timer_reg >= limit) begin
                    to_state_next = TO_IDLE;
                    to_err_next   = 1'b1;
                end else begin
                    timer_next = timer_reg + 12'h001;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            to_state_reg <= TO_IDLE;
            timer_reg    <= 12'h000;
            to_err_reg   <= 1'b0;
        end else begin
            to_state_reg <= to_state_next;
            timer_reg    <= timer_next;
            to_err_reg   <= to_err_next;
        end
    end

    // receive data path: direct or held
    assign hb.wr_valid = hold_en && rx_word_valid_in;
    assign hb.wr_index = rx_word_index_in;
    assign hb.wr_data  = rx_word_in;
    assign hb.commit   = hold_en && msg_done_in && !msg_error_in && !to_err_reg;
    assign hb.discard  = hold_en && (msg_error_in || to_err_reg);

    always_comb begin
        mem_we_next   = 1'b0;
        mem_addr_next = mem_addr_reg;
        mem_data_next = mem_data_reg;
        if (hold_en || hb.busy) begin
            mem_we_next = hb.mem_we;
            if (hb.mem_we) begin
                mem_addr_next = hb.mem_addr;
                mem_data_next = hb.mem_data;
            end
        end else if (rx_word_valid_in) begin
            mem_we_next   = 1'b1;
            mem_addr_next = rx_word_index_in;
            mem_data_next = rx_word_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_we_reg   <= 1'b0;
            mem_addr_reg <= 5'h00;
            mem_data_reg <= 16'h0000;
        end else begin
            mem_we_reg   <= mem_we_next;
            mem_addr_reg <= mem_addr_next;
            mem_data_reg <= mem_data_next;
        end
    end

    assign host_rdata_out                 = rdata_reg;
    assign rtrt_timeout_error_out         = to_err_reg;
    assign mem_we_out                     = mem_we_reg;
    assign mem_addr_out                   = mem_addr_reg;
    assign mem_data_out                   = mem_data_reg;
    assign time_tag_load_out              = load_reg;
    assign time_tag_value_out             = tt_value_reg;
    assign temp_receive_buffer_enable_out = cfg_reg[`RT_TRXB_BIT];

    reg_read_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        host_rd_in && cfg_hit |=> host_rdata_out == $past(cfg_reg))
        else $error("readback differs from register");
    soft_reset_keep_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        soft_reset_in && !host_wr_in && !load_reg |=> $stable(cfg_reg))
        else $error("register changed on soft reset");
    timeout_fire_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        to_state_reg == TO_WAIT && timer_reg >= limit && !rtrt_tx_begun_in |=> rtrt_timeout_error_out)
        else $error("timeout not flagged");
    timeout_exact_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        rtrt_timeout_error_out |-> $past(timer_reg) == $past(limit))
        else $error("timeout at wrong count");
    held_no_write_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        hold_en && !hb.busy && !hb.mem_we |=> !mem_we_out)
        else $error("memory written while holding");
    direct_write_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !hold_en && !hb.busy && rx_word_valid_in |=> mem_we_out && mem_data_out == $past(rx_word_in))
        else $error("direct word not written");
    load_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        host_wr_in && cfg_hit && !cfg_reg[`RT_TIME_TAG_LOAD_STROBE_BIT] && host_wdata_in[`RT_TIME_TAG_LOAD_STROBE_BIT]
        |=> time_tag_load_out && time_tag_value_out == $past(time_tag_utility_in))
        else $error("time-tag load missing");
    self_clear_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        time_tag_load_out && !(host_wr_in && cfg_hit) |=> !cfg_reg[`RT_TIME_TAG_LOAD_STROBE_BIT])
        else $error("load bit did not clear");
    single_load_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        time_tag_load_out |=> !time_tag_load_out)
        else $error("load pulse longer than one cycle");
endmodule

// *** host_model.sv ***
`timescale 1ns/1ns
module host_model (
    input  wire logic        sys_clk_in,
    input  wire logic [15:0] host_rdata_in,
    output logic             soft_reset_out,
    output logic      [15:0] host_addr_out,
    output logic             host_wr_out,
    output logic             host_rd_out,
    output logic      [15:0] host_wdata_out
);
    initial begin
        soft_reset_out = 1'b0;
        host_addr_out  = 16'h0000;
        host_wr_out    = 1'b0;
        host_rd_out    = 1'b0;
        host_wdata_out = 16'h0000;
    end
    // one-cycle write strobe, data turned to junk afterwards
    task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
        @(posedge sys_clk_in);
        #5;
        host_addr_out  = addr;
        host_wdata_out = data;
        host_wr_out    = 1'b1;
        @(posedge sys_clk_in);
        #5;
        host_wr_out    = 1'b0;
        host_wdata_out = ~data;
    endtask
    // one-cycle read strobe, data taken once registered
    task automatic read_reg(input logic [15:0] addr, output logic [15:0] data);
        @(posedge sys_clk_in);
        #5;
        host_addr_out = addr;
        host_rd_out   = 1'b1;
        @(posedge sys_clk_in);
        #5;
        host_rd_out   = 1'b0;
        @(posedge sys_clk_in);
        #5;
        data = host_rdata_in;
    endtask
    task automatic soft_pulse();
        @(posedge sys_clk_in);
        #5;
        soft_reset_out = 1'b1;
        @(posedge sys_clk_in);
        #5;
        soft_reset_out = 1'b0;
    endtask
endmodule

// *** rt_config_two_controls_bench.sv ***
`timescale 1ns/1ns
module rt_config_two_controls_bench;
    import rt_cfg2_pkg::*;
    logic        sys_clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        soft_reset_in, host_wr_in, host_rd_in, rtrt_timeout_error_out, mem_we_out;
    logic [15:0] host_addr_in, host_wdata_in, host_rdata_out, rx_word_in, mem_data_out;
    logic        rtrt_wait_start_in = 1'b0, rtrt_tx_begun_in = 1'b0, rx_word_valid_in = 1'b0;
    logic        msg_done_in = 1'b0, msg_error_in = 1'b0, time_tag_load_out, temp_receive_buffer_enable_out;
    logic [4:0]  rx_word_index_in = 5'h00, mem_addr_out;
    logic [15:0] time_tag_utility_in = 16'h0000, time_tag_value_out;
    int          err_total, compares, loads, errs, cycles;
    word_t       load_val, model, got;
    logic [20:0] exp_q[$], got_q[$];
    int          lim[4] = '{57 * 20, 100 * 20, 125 * 20, 150 * 20};
    initial rx_word_in = 16'h0000;
    always #25 sys_clk_in = ~sys_clk_in;
    host_model host_model_i (.sys_clk_in(sys_clk_in), .host_rdata_in(host_rdata_out),
        .soft_reset_out(soft_reset_in), .host_addr_out(host_addr_in), .host_wr_out(host_wr_in),
        .host_rd_out(host_rd_in), .host_wdata_out(host_wdata_in));
    rt_config_two_controls rt_config_two_controls_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .soft_reset_in(soft_reset_in), .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
        .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out),
        .rtrt_wait_start_in(rtrt_wait_start_in), .rtrt_tx_begun_in(rtrt_tx_begun_in),
        .rtrt_timeout_error_out(rtrt_timeout_error_out), .rx_word_valid_in(rx_word_valid_in),
        .rx_word_index_in(rx_word_index_in), .rx_word_in(rx_word_in), .msg_done_in(msg_done_in),
        .msg_error_in(msg_error_in), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
        .mem_data_out(mem_data_out), .time_tag_utility_in(time_tag_utility_in),
        .time_tag_load_out(time_tag_load_out), .time_tag_value_out(time_tag_value_out),
        .temp_receive_buffer_enable_out(temp_receive_buffer_enable_out));
    task automatic tally_and_finish();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp_word(input string name, input word_t exp, input word_t seen);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cmp_int(input string name, input int exp, input int seen);
        compares++;
        if (seen != exp) begin
            err_total++;
            $display("mismatch %s expected %0d seen %0d", name, exp, seen);
        end
    endtask
    // monitor of output pulses and the run ceiling
    always @(posedge sys_clk_in) begin
        cycles++;
        if (mem_we_out === 1'b1) got_q.push_back({mem_addr_out, mem_data_out});
        if (time_tag_load_out === 1'b1) begin
            loads++;
            load_val = time_tag_value_out;
        end
        if (rtrt_timeout_error_out === 1'b1) errs++;
        if (cycles == 40000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic wr_cfg(input word_t d);
        host_model_i.write_reg(16'h0001, d);
        model = d & 16'hE000;
    endtask
    task automatic chk_reg(input logic [15:0] addr, input word_t exp);
        host_model_i.read_reg(addr, got);
        cmp_word("rt_config_two", exp, got);
    endtask
    task automatic rx_send(input int idx, input word_t d);
        @(posedge sys_clk_in);
        #5;
        rx_word_valid_in = 1'b1;
        rx_word_index_in = idx[4:0];
        rx_word_in       = d;
        @(posedge sys_clk_in);
        #5;
        rx_word_valid_in = 1'b0;
        rx_word_in       = ~d;
    endtask
    // words 0..n-1 then message end, writes compared in order
    task automatic message(input int n, input logic hold, input logic bad);
        word_t d;
        logic [20:0] e, g;
        for (int i = 0; i < n; i++) begin
            d = word_t'($urandom);
            if (!hold || !bad) exp_q.push_back({i[4:0], d});
            rx_send(i, d);
        end
        @(posedge sys_clk_in);
        #5;
        msg_done_in  = 1'b1;
        msg_error_in = bad;
        @(posedge sys_clk_in);
        #5;
        msg_done_in  = 1'b0;
        msg_error_in = 1'b0;
        repeat (45) @(posedge sys_clk_in);
        cmp_int("mem write count", exp_q.size(), got_q.size());
        while (exp_q.size() > 0 && got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            cmp_word("mem entry", e[15:0], g[15:0]);
            cmp_word("mem index", {11'h000, e[20:16]}, {11'h000, g[20:16]});
        end
        exp_q.delete();
        got_q.delete();
    endtask
    // stop_at < 0: transmitter never begins
    task automatic timeout_run(input int sel, input int stop_at);
        int n, e0;
        n = 0;
        wr_cfg({sel[1:0], 14'h0000});
        e0 = errs;
        @(posedge sys_clk_in);
        #5;
        rtrt_wait_start_in = 1'b1;
        while (n < 3100 && rtrt_timeout_error_out !== 1'b1) begin
            @(posedge sys_clk_in);
            #5;
            rtrt_wait_start_in = 1'b0;
            rtrt_tx_begun_in   = (n == stop_at);
            n++;
        end
        repeat (3) @(posedge sys_clk_in);
        cmp_int("error pulses", (stop_at < 0) ? 1 : 0, errs - e0);
        if (stop_at < 0) cmp_int("timeout cycles", lim[sel] + 1, n);
    endtask
    initial begin
        void'($urandom(32'h8E8A898D));
        repeat (6) @(posedge sys_clk_in);
        #5;
        resetn_in = 1'b1;
        chk_reg(16'h0001, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr_cfg(word_t'($urandom) & 16'hEFFF);
            chk_reg(16'h0001, model);
        end
        host_model_i.write_reg(16'h0003, 16'hFFFF);
        chk_reg(16'h0002, 16'h0000);
        chk_reg(16'h0001, model);
        host_model_i.soft_pulse();
        chk_reg(16'h0001, model);
        for (int i = 0; i < 2; i++) begin
            time_tag_utility_in = word_t'($urandom);
            loads = 0;
            host_model_i.write_reg(16'h0001, model | 16'h1000);
            repeat (4) @(posedge sys_clk_in);
            cmp_int("load pulses", 1, loads);
            cmp_word("time tag value", time_tag_utility_in, load_val);
            chk_reg(16'h0001, model);
        end
        for (int s = 0; s < 4; s++) timeout_run(s, -1);
        timeout_run(0, 200);
        wr_cfg(16'h0000);
        cmp_word("buffer enable", 16'h0000, {15'h0000, temp_receive_buffer_enable_out});
        message(5, 1'b0, 1'b0);
        message(4, 1'b0, 1'b1);
        wr_cfg(16'h2000);
        cmp_word("buffer enable", 16'h0001, {15'h0000, temp_receive_buffer_enable_out});
        message(3, 1'b1, 1'b0);
        message(32, 1'b1, 1'b0);
        message(6, 1'b1, 1'b1);
        tally_and_finish();
    end
endmodule
